// file: src/cfm_pkg.sv
// Shared constants and types for the condition-code and exception unit.
// Assumes a single 200 MHz clock domain and an AHB-Lite register port.
`default_nettype none
package cfm_pkg;
	// Condition code bit positions.
	localparam int CCR_V = 7;
	localparam int CCR_H = 4;
	localparam int CCR_I = 3;
	localparam int CCR_N = 2;
	localparam int CCR_Z = 1;
	localparam int CCR_C = 0;
	localparam logic [7:0] CCR_FIXED = 8'h60;
	localparam logic [7:0] CCR_RST   = 8'h68;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Break vectors, normal and monitor mode.
	localparam logic [15:0] BRK_VEC     = 16'hFFFC;
	localparam logic [15:0] BRK_VEC_MON = 16'hFEFC;
	// Slot of the last automatic push.
	localparam logic [2:0] PUSH_LAST = 3'h4;
	// Default oscillator stabilisation count in clock cycles.
	localparam int unsigned STAB_CYCLES_DEF = 4096;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CCR  = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_PEND = 8'h0C;
	localparam int CTRL_MON = 0;
	localparam int STAT_BRK = 0;
	localparam int STAT_WAIT = 1;
	localparam int STAT_STOP = 2;
	localparam int STAT_STAB = 3;
	localparam int STAT_BUSY = 4;
	localparam int HTRANS_ACT = 1;
	localparam logic [23:0] RD_PAD = 24'h000000;

	typedef enum logic [2:0] {op_none, mask_clear_op, mask_set_op,
		return_from_interrupt_op, wait_op, stop_op} cfm_op_t;
	typedef enum logic [2:0] {alu_add, alu_adc, alu_sub, alu_sbc,
		alu_logic, alu_shift, alu_btst} cfm_alu_kind_t;
	typedef enum logic [2:0] {push_pcl, push_pch, push_x, push_a,
		push_ccr} cfm_slot_t;
	typedef enum logic [1:0] {st_run, st_push, st_vec} cfm_ent_t;
	typedef enum logic [1:0] {pw_run, pw_wait, pw_stop, pw_stab} cfm_pwr_t;

	typedef struct packed {
		logic          valid;
		cfm_alu_kind_t kind;
		logic [7:0]    a;
		logic [7:0]    m;
		logic [7:0]    res;
		logic          cout;
	} cfm_alu_t;

	typedef struct packed {
		logic [7:0] val;
		logic [7:0] wmask;
		logic [7:0] res;
	} cfm_flag_upd_t;

	typedef struct packed {
		logic       valid;
		cfm_slot_t  slot;
		logic [7:0] ccr;
	} cfm_push_t;

	typedef struct packed {
		logic        fetch;
		logic [15:0] addr;
		logic        load_ir;
		logic [7:0]  opcode;
	} cfm_vec_t;
endpackage
`default_nettype wire

// file: src/cfm_flags.sv
// Flag computation for one ALU result.
// Assumes the datapath supplies operands, its own result and shift carry.
`default_nettype none
module cfm_flags (
	input  wire cfm_pkg::cfm_alu_t      alu_i,
	input  wire logic                   carry_i,
	output cfm_pkg::cfm_flag_upd_t      upd_o
);
	import cfm_pkg::*;

	logic [8:0] sum9;
	logic [8:0] dif9;
	logic       cin;
	logic       is_add;
	logic       is_sub;
	logic [7:0] r;
	logic       v;
	logic       c;

	// Arithmetic is formed here so carry, half-carry and overflow agree.
	assign is_add = alu_i.kind == alu_add || alu_i.kind == alu_adc;
	assign is_sub = alu_i.kind == alu_sub || alu_i.kind == alu_sbc;
	assign cin = (alu_i.kind == alu_adc || alu_i.kind == alu_sbc) & carry_i;
	assign sum9 = {1'b0, alu_i.a} + {1'b0, alu_i.m} + {8'h00, cin};
	assign dif9 = {1'b0, alu_i.a} - {1'b0, alu_i.m} - {8'h00, cin};
	assign r = is_add ? sum9[7:0] : is_sub ? dif9[7:0] : alu_i.res;

	// Overflow and carry per operation class.
	always_comb begin
		v = 1'b0;
		c = alu_i.cout;
		if (is_add) begin
			v = (alu_i.a[7] & alu_i.m[7] & ~r[7])
				| (~alu_i.a[7] & ~alu_i.m[7] & r[7]);
			c = sum9[8];
		end else if (is_sub) begin
			v = (alu_i.a[7] & ~alu_i.m[7] & ~r[7])
				| (~alu_i.a[7] & alu_i.m[7] & r[7]);
			c = dif9[8];
		end else if (alu_i.kind == alu_shift) begin
			v = r[7] ^ alu_i.cout;
		end
	end

	// Flag values at their positions, and which flags this class writes.
	always_comb begin
		upd_o.res = r;
		upd_o.val = BYTE_ZERO;
		upd_o.val[CCR_V] = v;
		upd_o.val[CCR_H] = alu_i.a[4] ^ alu_i.m[4] ^ r[4];
		upd_o.val[CCR_N] = r[7];
		upd_o.val[CCR_Z] = r == BYTE_ZERO;
		upd_o.val[CCR_C] = c;
		upd_o.wmask = BYTE_ZERO;
		if (alu_i.kind != alu_btst) begin
			upd_o.wmask[CCR_V] = 1'b1;
			upd_o.wmask[CCR_N] = 1'b1;
			upd_o.wmask[CCR_Z] = 1'b1;
		end
		upd_o.wmask[CCR_H] = is_add;
		upd_o.wmask[CCR_C] = alu_i.kind != alu_logic;
	end
endmodule
`default_nettype wire

// file: src/cfm_stab.sv
// Oscillator stabilisation delay timer used when leaving stop.
// Assumes start arrives as a one-cycle pulse on mclk_i, not the gated core clock.
`default_nettype none
module cfm_stab #(
	parameter int unsigned CYCLES = cfm_pkg::STAB_CYCLES_DEF
) (
	input  wire logic mclk_i,
	input  wire logic rstn_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
	localparam logic [CW-1:0] ZERO = CW'(0);
	localparam logic [CW-1:0] ONE  = CW'(1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] age_reg;
	logic          busy_reg;

	assign busy_o = busy_reg;
	assign done_o = busy_reg && cnt_reg == ZERO;

	// Down-counter; done fires on the last cycle of the delay.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_reg <= ZERO;
			busy_reg <= 1'b0;
		end else if (start_i) begin
			cnt_reg <= LOAD;
			busy_reg <= 1'b1;
		end else if (busy_reg) begin
			busy_reg <= cnt_reg != ZERO;
			cnt_reg <= cnt_reg - ONE;
		end
	end

	// Age of the current delay, read only by the check below.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			age_reg <= ZERO;
		end else if (start_i) begin
			age_reg <= ZERO;
		end else if (busy_reg) begin
			age_reg <= age_reg + ONE;
		end
	end

	stab_length_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		done_o |-> age_reg == LOAD)
		else $error("stabilisation delay has the wrong length");
endmodule
`default_nettype wire

// file: src/cfm_unit.sv
// Condition codes, interrupt mask, interrupt and break entry, wait/stop.
// Assumes core, interrupt sources and break comparator share mclk_i.
//
// Behaviour
// - Mask set blocks maskable requests; clear accepts.
// - Mask sets after stacking, before vector fetch.
// - Entry never stacks the upper index byte.
// - Highest priority pending request served first.
// - Return op restores stacked registers and mask.
// - Reset sets mask; clear op clears it.
// - Negative flag equals result bit seven.
// - Zero flag set exactly for zero result.
// - Carry on add carry-out or subtract borrow.
// - Bit-test, shift, rotate also write carry.
// - Wait clears mask and halts core clock.
// - Stop clears mask and halts core clock.
// - After stop, clock waits for stabilisation.
// - Break loads trap opcode and break vector.
// - Break starts at instruction end, immediately.
// - Return in break ends it once released.
// - Register bits six and five read one.
// - Half carry from bit three on adds.
// - Overflow flag marks two's complement overflow.
`default_nettype none
module cfm_unit #(
	parameter int unsigned NIRQ        = 8,
	parameter int unsigned EXT_IDX     = 0,
	parameter int unsigned STAB_CYCLES = cfm_pkg::STAB_CYCLES_DEF,
	// Vector base and trap opcode values are arbitrary defaults.
	parameter logic [15:0] IRQ_VEC_TOP = 16'hFFFA,
	parameter logic [7:0]  TRAP_OPCODE = 8'h00
) (
	input  wire logic              mclk_i,
	input  wire logic              rstn_i,
	input  wire logic              hsel_i,
	input  wire logic [31:0]       haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic              hready_i,
	input  wire logic [31:0]       hwdata_i,
	output logic [31:0]            hrdata_o,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	input  wire logic              insn_last_i,
	input  wire cfm_pkg::cfm_op_t  op_i,
	input  wire cfm_pkg::cfm_alu_t alu_i,
	input  wire logic [7:0]        rti_ccr_i,
	input  wire logic [NIRQ-1:0]   irq_req_i,
	input  wire logic              brk_req_i,
	output logic [7:0]             ccr_o,
	output logic                   clk_en_o,
	output cfm_pkg::cfm_push_t     push_o,
	output cfm_pkg::cfm_vec_t      vec_o,
	output logic                   brk_active_o
);
	import cfm_pkg::*;

	localparam int IW = (NIRQ > 1) ? $clog2(NIRQ) : 1;
	localparam logic [2:0] SLOT_ONE = 3'h1;

	// Lowest index wins among pending requests.
	function automatic logic [IW-1:0] prio(input logic [NIRQ-1:0] p);
		prio = '0;
		for (int k = NIRQ - 1; k >= 0; k--) begin
			if (p[k]) begin
				prio = IW'(k);
			end
		end
	endfunction

	logic [7:0]    ccr_reg;
	logic [7:0]    ccr_next;
	cfm_ent_t      ent_reg;
	cfm_pwr_t      pwr_reg;
	logic [2:0]    slot_reg;
	logic [IW-1:0] src_reg;
	logic          brk_src_reg;
	logic          brk_act_reg;
	logic          wake_reg;
	logic          mon_reg;
	logic          wr_reg;
	logic          rd_reg;
	logic [7:0]    wa_reg;
	logic [7:0]    rd_byte;
	logic [7:0]    stat;
	cfm_flag_upd_t upd;
	cfm_op_t       op;
	logic          stab_busy;
	logic          stab_done;

	// Entry and wake conditions.
	wire           mask      = ccr_reg[CCR_I];
	wire           irq_ok    = (|irq_req_i) & ~mask;
	wire           run       = pwr_reg == pw_run;
	wire           idle      = ent_reg == st_run;
	wire           at_bound  = insn_last_i | wake_reg;
	wire           go        = idle & run & at_bound & (brk_req_i | irq_ok);
	wire [IW-1:0]  win       = prio(irq_req_i & {NIRQ{~mask}});
	wire           last_push = ent_reg == st_push && slot_reg == PUSH_LAST;
	wire           ext_wake  = irq_req_i[EXT_IDX] & ~mask;
	wire           stab_go   = pwr_reg == pw_stop && ext_wake;
	wire           alu_ok    = alu_i.valid & run & idle;
	wire           bus_go    = hsel_i & hready_i & htrans_i[HTRANS_ACT];
	wire           ccr_wr    = wr_reg && wa_reg == ADDR_CCR;
	wire           ctrl_wr   = wr_reg && wa_reg == ADDR_CTRL;
	wire [15:0]    irq_vec   = IRQ_VEC_TOP - 16'({src_reg, 1'b0});
	wire [15:0]    brk_vec   = mon_reg ? BRK_VEC_MON : BRK_VEC;

	// Core operations count only while the core clock runs.
	assign op = (run && idle) ? op_i : op_none;

	cfm_flags u_flags (
		.alu_i   (alu_i),
		.carry_i (ccr_reg[CCR_C]),
		.upd_o   (upd)
	);

	cfm_stab #(.CYCLES(STAB_CYCLES)) u_stab (
		.mclk_i  (mclk_i),
		.rstn_i  (rstn_i),
		.start_i (stab_go),
		.busy_o  (stab_busy),
		.done_o  (stab_done)
	);

	// Next condition code value; later writers take precedence.
	always_comb begin
		ccr_next = ccr_reg;
		if (ccr_wr) begin
			ccr_next = hwdata_i[7:0];
			ccr_next[CCR_I] = mask;
		end
		if (alu_ok) begin
			ccr_next = (ccr_next & ~upd.wmask) | (upd.val & upd.wmask);
		end
		case (op)
			mask_clear_op: ccr_next[CCR_I] = 1'b0;
			wait_op: ccr_next[CCR_I] = 1'b0;
			stop_op: ccr_next[CCR_I] = 1'b0;
			mask_set_op: ccr_next[CCR_I] = 1'b1;
			return_from_interrupt_op: ccr_next = rti_ccr_i;
			default: ccr_next = ccr_next;
		endcase
		if (last_push) begin
			ccr_next[CCR_I] = 1'b1;
		end
		ccr_next = ccr_next | CCR_FIXED;
	end

	// Condition code register; reset leaves the mask set.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ccr_reg <= CCR_RST;
		end else begin
			ccr_reg <= ccr_next;
		end
	end

	// Low-power state: wait and stop gate the core clock.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pwr_reg <= pw_run;
		end else begin
			case (pwr_reg)
				pw_run: begin
					if (op == wait_op) begin
						pwr_reg <= pw_wait;
					end else if (op == stop_op) begin
						pwr_reg <= pw_stop;
					end
				end
				pw_wait: begin
					if (irq_ok || brk_req_i) begin
						pwr_reg <= pw_run;
					end
				end
				pw_stop: begin
					if (ext_wake) begin
						pwr_reg <= pw_stab;
					end
				end
				default: begin
					if (stab_done) begin
						pwr_reg <= pw_run;
					end
				end
			endcase
		end
	end

	// Interrupt and break entry: five pushes, mask, then vector.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ent_reg <= st_run;
			slot_reg <= 3'h0;
			src_reg <= '0;
			brk_src_reg <= 1'b0;
		end else begin
			case (ent_reg)
				st_run: begin
					if (go) begin
						ent_reg <= st_push;
						slot_reg <= 3'h0;
						src_reg <= win;
						brk_src_reg <= brk_req_i;
					end
				end
				st_push: begin
					slot_reg <= slot_reg + SLOT_ONE;
					if (last_push) begin
						ent_reg <= st_vec;
					end
				end
				default: ent_reg <= st_run;
			endcase
		end
	end

	// Wake marker and break activity.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wake_reg <= 1'b0;
			brk_act_reg <= 1'b0;
		end else begin
			if (go) begin
				wake_reg <= 1'b0;
			end else if (!run && (pwr_reg == pw_wait ? (irq_ok | brk_req_i)
					: stab_done)) begin
				wake_reg <= 1'b1;
			end
			if (ent_reg == st_vec && brk_src_reg) begin
				brk_act_reg <= 1'b1;
			end else if (op == return_from_interrupt_op && !brk_req_i) begin
				brk_act_reg <= 1'b0;
			end
		end
	end

	// Core-facing outputs.
	assign ccr_o = ccr_reg;
	assign clk_en_o = run;
	assign brk_active_o = brk_act_reg;
	assign push_o.valid = ent_reg == st_push;
	assign push_o.slot = cfm_slot_t'(slot_reg);
	assign push_o.ccr = ccr_reg;
	assign vec_o.fetch = ent_reg == st_vec;
	assign vec_o.addr = brk_src_reg ? brk_vec : irq_vec;
	assign vec_o.load_ir = ent_reg == st_vec && brk_src_reg;
	assign vec_o.opcode = TRAP_OPCODE;

	// Bus slave: zero wait states, always OKAY.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			wa_reg <= ADDR_CCR;
		end else begin
			wr_reg <= bus_go & hwrite_i;
			rd_reg <= bus_go & ~hwrite_i;
			wa_reg <= haddr_i[7:0];
		end
	end

	// Control register write: monitor mode selects the break vector.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mon_reg <= 1'b0;
		end else if (ctrl_wr) begin
			mon_reg <= hwdata_i[CTRL_MON];
		end
	end

	// Status byte.
	always_comb begin
		stat = BYTE_ZERO;
		stat[STAT_BRK] = brk_act_reg;
		stat[STAT_WAIT] = pwr_reg == pw_wait;
		stat[STAT_STOP] = pwr_reg == pw_stop;
		stat[STAT_STAB] = stab_busy;
		stat[STAT_BUSY] = !idle;
	end

	// Read decode; unmapped addresses read zero.
	always_comb begin
		if (wa_reg == ADDR_CCR) begin
			rd_byte = ccr_reg;
		end else if (wa_reg == ADDR_CTRL) begin
			rd_byte = {7'h00, mon_reg};
		end else if (wa_reg == ADDR_STAT) begin
			rd_byte = stat;
		end else if (wa_reg == ADDR_PEND) begin
			rd_byte = 8'(irq_req_i);
		end else begin
			rd_byte = BYTE_ZERO;
		end
	end

	assign hrdata_o = rd_reg ? {RD_PAD, rd_byte} : 32'h00000000;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_stacking;
		(ent_reg == st_push)[*5];
	endsequence
	sequence s_vector;
		ent_reg == st_vec && ccr_reg[CCR_I] && vec_o.fetch;
	endsequence

	mask_blocks_a: assert property (idle && mask && !brk_req_i
		|=> ent_reg != st_push) else $error("masked request taken");
	irq_taken_a: assert property (run && idle && insn_last_i && irq_ok
		|=> ent_reg == st_push) else $error("unmasked request ignored");
	stack_then_mask_a: assert property ($rose(ent_reg == st_push)
		|-> !ccr_reg[CCR_I] || $past(ccr_reg[CCR_I]) ##0 s_stacking ##1 s_vector)
		else $error("mask not set between stacking and vector");
	five_pushes_a: assert property (push_o.valid && push_o.slot == push_ccr
		|=> !push_o.valid) else $error("extra register stacked");
	prio_pick_a: assert property (go && !brk_req_i && irq_req_i[0]
		|=> src_reg == '0) else $error("lower priority request served");
	rti_restore_a: assert property (op == return_from_interrupt_op
		|=> ccr_reg == ($past(rti_ccr_i) | CCR_FIXED))
		else $error("return did not restore flags");
	mask_fall_a: assert property ($fell(ccr_reg[CCR_I]) |->
		$past(op) inside {mask_clear_op, wait_op, stop_op,
		return_from_interrupt_op}) else $error("mask cleared illegally");
	nz_flags_a: assert property (alu_ok && op == op_none
		&& upd.wmask[CCR_N] |=> ccr_reg[CCR_N] == $past(upd.res[7])
		&& ccr_reg[CCR_Z] == ($past(upd.res) == BYTE_ZERO))
		else $error("negative or zero flag wrong");
	add_carry_a: assert property (alu_ok && op == op_none
		&& alu_i.kind == alu_add |=> ccr_reg[CCR_C] ==
		$past(alu_i.a[7] & alu_i.m[7] | (alu_i.a[7] ^ alu_i.m[7])
		& ~upd.res[7]) && ccr_reg[CCR_H] == $past(upd.val[CCR_H]))
		else $error("add carry flags wrong");
	wait_halt_a: assert property (op == wait_op
		|=> !ccr_reg[CCR_I] && !clk_en_o) else $error("wait misbehaved");
	stop_halt_a: assert property (op == stop_op
		|=> !ccr_reg[CCR_I] && pwr_reg == pw_stop) else $error("stop misbehaved");
	stab_hold_a: assert property (pwr_reg == pw_stab && !stab_done
		|=> !clk_en_o) else $error("clock resumed before delay");
	brk_entry_a: assert property (run && idle && insn_last_i && brk_req_i
		|-> ##6 (vec_o.load_ir && vec_o.addr == brk_vec))
		else $error("break entry wrong");
	brk_end_a: assert property (op == return_from_interrupt_op
		&& brk_req_i && brk_act_reg |=> brk_active_o)
		else $error("break ended while still requested");
	fixed_ones_a: assert property ((ccr_o & CCR_FIXED) == CCR_FIXED)
		else $error("fixed condition code bits not one");
endmodule
`default_nettype wire

// file: verification/cfm_src_model.sv
// Interrupt sources and break comparator facing the exception unit.
// Assumes the bench raises requests as one-cycle pulses on mclk_i.
`default_nettype none
module cfm_src_model #(
	parameter int unsigned NIRQ        = 8,
	parameter logic [15:0] IRQ_VEC_TOP = 16'hFFFA
) (
	input  wire logic            mclk_i,
	input  wire logic            rstn_i,
	input  wire logic [NIRQ-1:0] raise_i,
	input  wire logic            brk_raise_i,
	input  wire cfm_pkg::cfm_vec_t vec_i,
	output logic [NIRQ-1:0]      irq_o,
	output logic                 brk_o
);
	import cfm_pkg::*;

	// Each source holds its request until its own vector is fetched.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= '0;
			brk_o <= 1'h0;
		end else begin
			for (int k = 0; k < NIRQ; k++) begin
				if (raise_i[k])
					irq_o[k] <= 1'h1;
				else if (vec_i.fetch && !vec_i.load_ir &&
					vec_i.addr == IRQ_VEC_TOP - 16'(2 * k))
					irq_o[k] <= 1'h0;
			end
			if (brk_raise_i)
				brk_o <= 1'h1;
			else if (vec_i.load_ir)
				brk_o <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// file: verification/test_cpu_flags_irq_mask_standby.sv
// Self-checking bench for the condition-code and exception unit.
// Assumes the unit answers register accesses with zero wait states.
`default_nettype none
module test_cpu_flags_irq_mask_standby;
	timeunit 1ns;
	timeprecision 100ps;
	import cfm_pkg::*;
	localparam int unsigned NQ   = 8;
	localparam int unsigned STAB = 8;
	localparam logic [15:0] TOP  = 16'hFFFA;
	localparam logic [7:0]  TRAP = 8'hA5;

	logic          mclk_i = 1'h0;
	logic          rstn_i = 1'h0;
	logic          hsel_i = 1'h0;
	logic          hwrite_i = 1'h0;
	logic          insn_last_i = 1'h0;
	logic          brk_raise = 1'h0;
	logic          hreadyout_o, hresp_o, clk_en_o, brk_active_o, brk_req;
	logic [1:0]    htrans_i = 2'h0;
	logic [31:0]   haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
	logic [7:0]    rti_ccr_i = 8'h00, ccr_o, expc;
	logic [NQ-1:0] raise = '0, irq_req;
	cfm_op_t       op_i = op_none;
	cfm_alu_t      alu_i = '0;
	cfm_push_t     push_o;
	cfm_vec_t      vec_o;
	int            num_errors = 0, num_checks = 0, cycles = 0;

	cfm_unit #(.NIRQ(NQ), .EXT_IDX(0), .STAB_CYCLES(STAB),
		.IRQ_VEC_TOP(TOP), .TRAP_OPCODE(TRAP)) cfm_unit_i (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i(hwdata_i),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.insn_last_i(insn_last_i), .op_i(op_i), .alu_i(alu_i),
		.rti_ccr_i(rti_ccr_i), .irq_req_i(irq_req), .brk_req_i(brk_req),
		.ccr_o(ccr_o), .clk_en_o(clk_en_o), .push_o(push_o),
		.vec_o(vec_o), .brk_active_o(brk_active_o));

	cfm_src_model #(.NIRQ(NQ), .IRQ_VEC_TOP(TOP)) cfm_src_model_i (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .raise_i(raise),
		.brk_raise_i(brk_raise), .vec_i(vec_o), .irq_o(irq_req),
		.brk_o(brk_req));

	// Clock and a cycle ceiling that cuts a hang short.
	always #2.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One single-word transfer; waits for hready in both phases and
	// leaves a hang to the bench's cycle ceiling.
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk_i);
		hsel_i <= 1'h1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		@(posedge mclk_i);
		while (hreadyout_o !== 1'h1) begin
			@(posedge mclk_i);
		end
		htrans_i <= 2'h0;
		hsel_i <= 1'h0;
		hwdata_i <= wd;
		@(posedge mclk_i);
		while (hreadyout_o !== 1'h1) begin
			@(posedge mclk_i);
		end
		rd = hrdata_o;
	endtask

	// Read one register and compare it; the response must be OKAY.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'h0, a, 32'h0, d);
		chk(d, exp);
		chk(hresp_o, 32'h0);
	endtask

	task automatic do_op(input cfm_op_t o, input logic [7:0] r);
		@(posedge mclk_i);
		op_i <= o;
		rti_ccr_i <= r;
		@(posedge mclk_i);
		op_i <= op_none;
		#1;
	endtask

	task automatic do_reset();
		@(posedge mclk_i);
		rstn_i <= 1'h0;
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'h1;
		#1;
	endtask

	task automatic raise_irq(input logic [NQ-1:0] b, input logic k);
		@(posedge mclk_i);
		raise <= b;
		brk_raise <= k;
		@(posedge mclk_i);
		raise <= '0;
		brk_raise <= 1'h0;
	endtask

	// Follows one entry: five pushes with the mask still clear, then fetch.
	task automatic entry(input logic last, input logic [15:0] va,
		input logic brk);
		int n;
		n = 0;
		if (last) begin
			@(posedge mclk_i);
			insn_last_i <= 1'h1;
			@(posedge mclk_i);
			insn_last_i <= 1'h0;
		end
		#1;
		while (push_o.valid !== 1'h1 && n < 40) begin
			n++;
			@(posedge mclk_i);
			#1;
		end
		if (last)
			chk(n, 0);
		for (int k = 0; k < 5; k++) begin
			chk({push_o.valid, push_o.slot}, {1'h1, 3'(k)});
			chk({ccr_o[CCR_I], push_o.ccr[CCR_I]}, 2'h0);
			@(posedge mclk_i);
			#1;
		end
		chk({vec_o.fetch, vec_o.addr, vec_o.load_ir}, {1'h1, va, brk});
		if (brk)
			chk(vec_o.opcode, TRAP);
		chk(ccr_o[CCR_I], 1'h1);
		@(posedge mclk_i);
		#1;
		chk({push_o.valid, vec_o.fetch}, 2'h0);
	endtask

	// Expected flags worked out from the operands, old flags kept elsewhere.
	function automatic logic [7:0] flags(input logic [7:0] c,
		input cfm_alu_t u);
		logic [8:0] s;
		logic [4:0] h;
		logic       ci;
		ci = (u.kind == alu_adc || u.kind == alu_sbc) ? c[CCR_C] : 1'h0;
		s = {1'h0, u.res};
		case (u.kind)
			alu_add, alu_adc: begin
				s = u.a + u.m + ci;
				h = u.a[3:0] + u.m[3:0] + ci;
				c[CCR_H] = h[4];
				c[CCR_V] = (u.a[7] == u.m[7]) && (s[7] != u.a[7]);
				c[CCR_C] = s[8];
			end
			alu_sub, alu_sbc: begin
				s = u.a - u.m - ci;
				c[CCR_V] = (u.a[7] != u.m[7]) && (s[7] != u.a[7]);
				c[CCR_C] = s[8];
			end
			alu_logic: c[CCR_V] = 1'h0;
			alu_shift: begin
				c[CCR_C] = u.cout;
				c[CCR_V] = s[7] ^ u.cout;
			end
			default: begin
				c[CCR_C] = u.cout;
				return c;
			end
		endcase
		c[CCR_N] = s[7];
		c[CCR_Z] = (s[7:0] == BYTE_ZERO);
		return c;
	endfunction

	task automatic alu(input cfm_alu_kind_t k, input logic [7:0] a, m, r,
		input logic co);
		expc = flags(ccr_o, cfm_alu_t'{1'h1, k, a, m, r, co});
		@(posedge mclk_i);
		alu_i <= '{1'h1, k, a, m, r, co};
		@(posedge mclk_i);
		alu_i.valid <= 1'h0;
		#1;
		chk(ccr_o, expc);
	endtask

	// Main sequence of register, interrupt, flag, standby and break tests.
	initial begin
		logic [31:0] d;
		int          n;
		do_reset();
		chk(ccr_o, CCR_RST);
		rd_chk(ADDR_CCR, 32'h68);
		ahb(1'h1, ADDR_CCR, 32'h97, d);
		rd_chk(ADDR_CCR, 32'hFF);
		ahb(1'h1, ADDR_CCR, 32'h00, d);
		rd_chk(ADDR_CCR, 32'h68);
		rd_chk(8'h10, 32'h0);
		raise_irq(8'h24, 1'h0);
		@(posedge mclk_i);
		insn_last_i <= 1'h1;
		@(posedge mclk_i);
		insn_last_i <= 1'h0;
		repeat (8) begin
			@(posedge mclk_i);
			#1;
			chk(push_o.valid, 1'h0);
		end
		rd_chk(ADDR_PEND, 32'h24);
		do_op(mask_clear_op, 8'h00);
		chk(ccr_o, 8'h60);
		entry(1'h1, TOP - 16'h4, 1'h0);
		do_op(return_from_interrupt_op, 8'h60);
		chk(ccr_o, 8'h60);
		entry(1'h1, TOP - 16'hA, 1'h0);
		do_op(return_from_interrupt_op, 8'h68);
		chk(ccr_o, 8'h68);
		alu(alu_add, 8'h80, 8'h80, 8'h00, 1'h0);
		alu(alu_adc, 8'h0F, 8'h00, 8'h00, 1'h0);
		alu(alu_sub, 8'h00, 8'h01, 8'h00, 1'h0);
		alu(alu_sbc, 8'h80, 8'h00, 8'h00, 1'h0);
		alu(alu_logic, 8'h00, 8'h00, 8'h00, 1'h0);
		alu(alu_shift, 8'h00, 8'h00, 8'h80, 1'h0);
		alu(alu_btst, 8'h00, 8'h00, 8'h00, 1'h1);
		ahb(1'h1, ADDR_CCR, 32'h00, d);
		do_op(wait_op, 8'h00);
		chk({ccr_o[CCR_I], clk_en_o}, 2'h0);
		rd_chk(ADDR_STAT, 32'h2);
		raise_irq(8'h02, 1'h0);
		entry(1'h0, TOP - 16'h2, 1'h0);
		do_op(return_from_interrupt_op, 8'h60);
		do_op(wait_op, 8'h00);
		do_reset();
		chk({ccr_o, clk_en_o}, {CCR_RST, 1'h1});
		do_op(stop_op, 8'h00);
		chk({ccr_o[CCR_I], clk_en_o}, 2'h0);
		raise_irq(8'h01, 1'h0);
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
		end while (clk_en_o !== 1'h1 && n < 100);
		// The first edge wakes the stop logic, then the delay runs out.
		chk(n, STAB + 1);
		entry(1'h0, TOP, 1'h0);
		do_op(return_from_interrupt_op, 8'h60);
		do_op(stop_op, 8'h00);
		do_reset();
		chk(ccr_o, CCR_RST);
		do_op(mask_clear_op, 8'h00);
		raise_irq('0, 1'h1);
		entry(1'h1, BRK_VEC, 1'h1);
		chk(brk_active_o, 1'h1);
		do_op(return_from_interrupt_op, 8'h60);
		chk(brk_active_o, 1'h0);
		ahb(1'h1, ADDR_CTRL, 32'h1, d);
		raise_irq('0, 1'h1);
		entry(1'h1, BRK_VEC_MON, 1'h1);
		// A return while the comparator still asks keeps the break.
		raise_irq('0, 1'h1);
		do_op(return_from_interrupt_op, 8'h60);
		chk(brk_active_o, 1'h1);
		entry(1'h1, BRK_VEC_MON, 1'h1);
		do_op(return_from_interrupt_op, 8'h60);
		chk({brk_active_o, ccr_o}, 9'h060);
		finish_test();
	end
endmodule
`default_nettype wire
